// ===== verilog/sigr_unit.sv
// Interrupt gate, exception return and move-from unit of the coprocessor.
// Operation
// - Mask-all clears enable when permitted or privileged.
// - Enable clear blocks all but nonmaskable, serial.
// - Unmask sets enable under same permission.
// - Enable set: accept if global, no levels.
// - Permit bit opens gate ops to all modes.
// - Return with error level uses error pc.
// - Otherwise return uses exception pc, clears level.
// - Return redirects fetch without delay slot.
// - Return flushes pipelines before target fetch.
// - Flush spares loads, stores, multiplies, coprocessor.
// - Move-from copies register, sign extended.
// - Debug selector 000 reads break control.
// - Selectors 100, 101 read data address pair.
// - Selectors 110, 111 read data value pair.
// - Selector 011 reads instruction address mask.
`timescale 1ns/100ps
`default_nettype none
module sigr_unit (
  // Clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      resetn_in,
  // Instruction issue
  input  wire logic                      issue_valid_in,
  input  wire logic                      irq_mask_all_op_in,
  input  wire logic                      irq_unmask_op_in,
  input  wire logic                      exception_return_op_in,
  input  wire logic [31:0]               instr_word_in,
  // Status state from the status register
  input  wire logic                      global_interrupt_enable_in,
  input  wire logic                      user_irq_gate_permit_in,
  input  wire logic [1:0]                privilege_mode_field_in,
  input  wire logic                      coproc_usable_in,
  input  wire logic                      exception_level_in,
  input  wire logic                      error_level_in,
  input  wire logic [63:0]               exception_return_pc_in,
  input  wire logic [63:0]               error_return_pc_in,
  // Interrupt requests
  input  wire logic                      maskable_irq_in,
  input  wire logic                      serial_port_interrupt_in,
  input  wire logic                      nonmaskable_irq_in,
  // Register sources
  input  wire logic [31:0]               sysctl_reg_data_in,
  input  wire logic [31:0]               break_control_in,
  input  wire logic [31:0]               instr_addr_break_in,
  input  wire logic [31:0]               instr_addr_mask_in,
  input  wire logic [31:0]               data_addr_break_in,
  input  wire logic [31:0]               data_addr_mask_in,
  input  wire logic [31:0]               data_value_break_in,
  input  wire logic [31:0]               data_value_mask_in,
  // Interrupt gate
  output var logic                       extra_interrupt_enable_out,
  output var logic                       irq_take_out,
  // Exception return
  output var logic                       clear_exception_level_out,
  output var logic                       clear_error_level_out,
  output var logic                       fetch_redirect_out,
  output var logic [63:0]                fetch_pc_out,
  output var logic                       pipe_flush_out,
  output var logic                       spare_long_ops_out,
  // Register read result
  output var logic                       gpr_write_out,
  output var logic [4:0]                 target_gpr_field_out,
  output var logic [63:0]                gpr_data_out
);
  import sigr_pkg::*;

  sigr_kind_t  kind;
  logic        gate_allowed;
  logic        is_move_from;
  logic        is_debug;
  logic        read_hit;
  logic [31:0] read_word;
  logic [4:0]  source_cp_reg_field;
  logic [2:0]  debug_sel;

  function automatic logic [63:0] sign_extend(input logic [31:0] w);
    sign_extend = {{32{w[31]}}, w};
  endfunction : sign_extend

  // ****************************************
  // Decode
  // ****************************************
  always_comb begin
    if (!issue_valid_in) begin
      kind = SIGR_K_NONE;
    end else if (irq_mask_all_op_in) begin
      kind = SIGR_K_DI;
    end else if (irq_unmask_op_in) begin
      kind = SIGR_K_EI;
    end else if (exception_return_op_in) begin
      kind = SIGR_K_EXCEPTION_RETURN_OP;
    end else begin
      kind = SIGR_K_NONE;
    end
  end

  // permit any mode
  // The usable bit plays no part in the gate ops.
  assign gate_allowed = user_irq_gate_permit_in || exception_level_in ||
                        error_level_in ||
                        (privilege_mode_field_in == SIGR_MODE_KERNEL);

  assign source_cp_reg_field = instr_word_in[SIGR_RD_HI:SIGR_RD_LO];
  assign debug_sel           = instr_word_in[SIGR_SEL_HI:SIGR_SEL_LO];
  assign is_move_from = issue_valid_in && (kind == SIGR_K_NONE) &&
    (instr_word_in[SIGR_OP_HI:SIGR_OP_LO] == SIGR_OP_SYSCTL) &&
    (instr_word_in[SIGR_SUB_HI:SIGR_SUB_LO] == SIGR_SUB_MOVEFROM);
  assign is_debug = (source_cp_reg_field == SIGR_DEBUG_GROUP) &&
                    (instr_word_in[SIGR_PAD_HI:SIGR_PAD_LO] == 8'h00);

  // ****************************************
  // Move-from source select
  // ****************************************
  always_comb begin
    read_word = 32'h0;
    read_hit  = 1'b0;
    if (is_move_from && is_debug) begin
      read_hit = 1'b1;
      case (debug_sel)
        SIGR_SEL_BPC:  read_word = break_control_in;
        SIGR_SEL_IAB:  read_word = instr_addr_break_in;
        SIGR_SEL_IABM: read_word = instr_addr_mask_in;
        SIGR_SEL_DAB:  read_word = data_addr_break_in;
        SIGR_SEL_DABM: read_word = data_addr_mask_in;
        SIGR_SEL_DVB:  read_word = data_value_break_in;
        SIGR_SEL_DVBM: read_word = data_value_mask_in;
        default:       read_hit  = 1'b0;
      endcase
    end else if (is_move_from &&
                 instr_word_in[SIGR_PAD_HI:SIGR_SEL_LO] == 11'h000) begin
      read_hit  = 1'b1;
      read_word = sysctl_reg_data_in;
    end
  end

  // ****************************************
  // Extra interrupt enable
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      extra_interrupt_enable_out <= SIGR_EIE_RESET;
    end else if (gate_allowed) begin
      case (kind)
        SIGR_K_DI: extra_interrupt_enable_out <= 1'b0;
        SIGR_K_EI: extra_interrupt_enable_out <= 1'b1;
        default:   extra_interrupt_enable_out <= extra_interrupt_enable_out;
      endcase
    end
  end

  // ****************************************
  // Interrupt acceptance
  // ****************************************
  // evaluated each clock
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_take_out <= 1'b0;
    end else begin
      irq_take_out <= nonmaskable_irq_in || serial_port_interrupt_in ||
        (maskable_irq_in && extra_interrupt_enable_out &&
         global_interrupt_enable_in && !exception_level_in &&
         !error_level_in);
    end
  end

  // ****************************************
  // Exception return
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clear_exception_level_out <= 1'b0;
      clear_error_level_out     <= 1'b0;
      fetch_redirect_out        <= 1'b0;
      fetch_pc_out              <= 64'h0;
      pipe_flush_out            <= 1'b0;
      spare_long_ops_out        <= 1'b0;
    end else begin
      fetch_redirect_out <= (kind == SIGR_K_EXCEPTION_RETURN_OP);
      pipe_flush_out     <= (kind == SIGR_K_EXCEPTION_RETURN_OP);
      spare_long_ops_out <= (kind == SIGR_K_EXCEPTION_RETURN_OP);
      clear_error_level_out <= (kind == SIGR_K_EXCEPTION_RETURN_OP) && error_level_in;
      clear_exception_level_out <= (kind == SIGR_K_EXCEPTION_RETURN_OP) && !error_level_in;
      if (kind == SIGR_K_EXCEPTION_RETURN_OP) begin
        fetch_pc_out <= error_level_in ? error_return_pc_in
                                       : exception_return_pc_in;
      end
    end
  end

  // ****************************************
  // General register write
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gpr_write_out        <= 1'b0;
      target_gpr_field_out <= 5'h00;
      gpr_data_out         <= 64'h0;
    end else begin
      gpr_write_out <= read_hit;
      if (read_hit) begin
        target_gpr_field_out <= instr_word_in[SIGR_RT_HI:SIGR_RT_LO];
        gpr_data_out         <= sign_extend(read_word);
      end
    end
  end
endmodule : sigr_unit
`default_nettype wire

// ===== verilog/sigr_pkg.sv
// Package of constants for the system control interrupt gate and return unit.
`default_nettype none
package sigr_pkg;
  // ****************************************
  // Instruction encoding
  // ****************************************
  localparam logic [5:0] SIGR_OP_SYSCTL    = 6'h10;
  localparam logic [4:0] SIGR_SUB_MOVEFROM = 5'h00;
  localparam logic [4:0] SIGR_DEBUG_GROUP  = 5'h18;
  localparam int         SIGR_OP_HI        = 31;
  localparam int         SIGR_OP_LO        = 26;
  localparam int         SIGR_SUB_HI       = 25;
  localparam int         SIGR_SUB_LO       = 21;
  localparam int         SIGR_RT_HI        = 20;
  localparam int         SIGR_RT_LO        = 16;
  localparam int         SIGR_RD_HI        = 15;
  localparam int         SIGR_RD_LO        = 11;
  localparam int         SIGR_PAD_HI       = 10;
  localparam int         SIGR_PAD_LO       = 3;
  localparam int         SIGR_SEL_HI       = 2;
  localparam int         SIGR_SEL_LO       = 0;
  // ****************************************
  // Debug register selectors
  // ****************************************
  localparam logic [2:0] SIGR_SEL_BPC   = 3'h0;
  localparam logic [2:0] SIGR_SEL_IAB   = 3'h2;
  localparam logic [2:0] SIGR_SEL_IABM  = 3'h3;
  localparam logic [2:0] SIGR_SEL_DAB   = 3'h4;
  localparam logic [2:0] SIGR_SEL_DABM  = 3'h5;
  localparam logic [2:0] SIGR_SEL_DVB   = 3'h6;
  localparam logic [2:0] SIGR_SEL_DVBM  = 3'h7;
  // ****************************************
  // Status fields
  // ****************************************
  localparam int         SIGR_EXL_BIT   = 1;
  localparam int         SIGR_ERL_BIT   = 2;
  localparam logic [1:0] SIGR_MODE_KERNEL = 2'h0;
  localparam logic       SIGR_EIE_RESET = 1'h1;
  // ****************************************
  // Operation kinds
  // ****************************************
  typedef enum logic [3:0] {
    SIGR_K_NONE  = 4'h1,
    SIGR_K_DI    = 4'h2,
    SIGR_K_EI    = 4'h4,
    SIGR_K_EXCEPTION_RETURN_OP  = 4'h8
  } sigr_kind_t;
endpackage : sigr_pkg
`default_nettype wire

// ===== verif/sigr_unit_monitor.sv
// Assertion checker bound to the interrupt gate and return unit.
`timescale 1ns/100ps
`default_nettype none
module sigr_unit_monitor (
  input wire logic        ref_clk_in, resetn_in, issue_valid_in,
  input wire logic        irq_mask_all_op_in, irq_unmask_op_in,
  input wire logic        exception_return_op_in, global_interrupt_enable_in,
  input wire logic        user_irq_gate_permit_in, exception_level_in,
  input wire logic        error_level_in, maskable_irq_in,
  input wire logic        serial_port_interrupt_in, nonmaskable_irq_in,
  input wire logic [1:0]  privilege_mode_field_in,
  input wire logic [31:0] instr_word_in, break_control_in,
  input wire logic [63:0] exception_return_pc_in, error_return_pc_in,
  input wire logic        extra_interrupt_enable_out, irq_take_out,
  input wire logic        clear_exception_level_out, clear_error_level_out,
  input wire logic        fetch_redirect_out, pipe_flush_out,
  input wire logic        spare_long_ops_out, gpr_write_out,
  input wire logic [4:0]  target_gpr_field_out,
  input wire logic [63:0] fetch_pc_out, gpr_data_out
);
  import sigr_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic extra_interrupt_enable = extra_interrupt_enable_out;
  wire logic ok = user_irq_gate_permit_in | exception_level_in |
    error_level_in | (privilege_mode_field_in == SIGR_MODE_KERNEL);
  wire logic dis = issue_valid_in & irq_mask_all_op_in;
  wire logic ena = issue_valid_in & irq_unmask_op_in & !irq_mask_all_op_in;
  wire logic ret = issue_valid_in & exception_return_op_in & !dis & !ena;
  wire logic bpc = issue_valid_in & !irq_mask_all_op_in & !irq_unmask_op_in &
    !exception_return_op_in & ((instr_word_in & 32'hffe0ffff) == 32'h4000c000);
  wire logic fl = fetch_redirect_out & pipe_flush_out & spare_long_ops_out;
  wire logic take = nonmaskable_irq_in | serial_port_interrupt_in |
    (maskable_irq_in & global_interrupt_enable_in & extra_interrupt_enable &
    !exception_level_in & !error_level_in);
  wire logic [4:0]  rt = instr_word_in[20:16];
  wire logic [63:0] bcx = {{32{break_control_in[31]}}, break_control_in};
  mask_clear_a: assert property (dis && ok |=> !extra_interrupt_enable)
    else $error("mask-all kept enable");
  unmask_set_a: assert property (ena && ok |=> extra_interrupt_enable)
    else $error("unmask left enable clear");
  gate_hold_a: assert property (
    !((dis || ena) && ok) |=> $stable(extra_interrupt_enable))
    else $error("enable changed without permitted op");
  irq_accept_a: assert property (
    1 |=> irq_take_out == $past(take))
    else $error("interrupt acceptance wrong");
  err_ret_a: assert property (
    ret && error_level_in |=> fl &&
    clear_error_level_out && !clear_exception_level_out &&
    fetch_pc_out == $past(error_return_pc_in))
    else $error("error return wrong");
  exc_ret_a: assert property (
    ret && !error_level_in |=> fl &&
    clear_exception_level_out && !clear_error_level_out &&
    fetch_pc_out == $past(exception_return_pc_in))
    else $error("return wrong");
  no_redirect_a: assert property (!ret |=> !fetch_redirect_out)
    else $error("redirect without return");
  debug_read_a: assert property (bpc |=> gpr_write_out &&
    target_gpr_field_out == $past(rt) && gpr_data_out == $past(bcx))
    else $error("break control read wrong");
  cover property (dis && !ok);
  cover property (ret && error_level_in);
  cover property (bpc);
endmodule : sigr_unit_monitor
bind sigr_unit sigr_unit_monitor u_mon (.*);
`default_nettype wire

// ===== verif/sigr_pipe_model.sv
// Pipeline-side model supplying register contents and return addresses.
`timescale 1ns/100ps
`default_nettype none
module sigr_pipe_model (
  // Pattern select
  input  wire logic [7:0]  seed_in,
  // Register contents indexed by debug selector, return addresses
  output var logic  [31:0] regs_out [8],
  output var logic  [63:0] exc_pc_out,
  output var logic  [63:0] err_pc_out
);
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      regs_out[k] = {seed_in ^ 8'(k), 8'(k * 17), ~seed_in, 8'h3c};
    end
    exc_pc_out = {24'h800000, seed_in, 32'h00001000};
    err_pc_out = ~exc_pc_out;
  end
endmodule : sigr_pipe_model
`default_nettype wire

// ===== verif/sigr_unit_tb_top.sv
// Self-checking testbench of the interrupt gate and return unit.
`timescale 1ns/100ps
`default_nettype none
module sigr_unit_tb_top;
  import sigr_pkg::*;
  logic ref_clk_in = 1'b0, resetn_in = 1'b0, issue_valid_in = 1'b0;
  logic irq_mask_all_op_in = 1'b0, irq_unmask_op_in = 1'b0;
  logic exception_return_op_in = 1'b0, coproc_usable_in = 1'b0;
  logic global_interrupt_enable_in = 1'b0, user_irq_gate_permit_in = 1'b0;
  logic exception_level_in = 1'b0, error_level_in = 1'b0;
  logic maskable_irq_in = 1'b0, serial_port_interrupt_in = 1'b0;
  logic nonmaskable_irq_in = 1'b0;
  logic [1:0]  privilege_mode_field_in = 2'h0;
  logic [7:0]  seed_in = 8'h00;
  logic [31:0] instr_word_in = 32'h0, regs_out [8];
  logic [31:0] sysctl_reg_data_in, break_control_in, instr_addr_break_in;
  logic [31:0] instr_addr_mask_in, data_addr_break_in, data_addr_mask_in;
  logic [31:0] data_value_break_in, data_value_mask_in;
  logic [63:0] exception_return_pc_in, error_return_pc_in;
  logic [63:0] fetch_pc_out, gpr_data_out;
  logic        extra_interrupt_enable_out, irq_take_out, gpr_write_out;
  logic        clear_exception_level_out, clear_error_level_out;
  logic        fetch_redirect_out, pipe_flush_out, spare_long_ops_out;
  logic [4:0]  target_gpr_field_out;
  int          bad_count = 0, num_checks = 0, cyc = 0;
  assign break_control_in = regs_out[0];
  assign sysctl_reg_data_in = regs_out[1];
  assign instr_addr_break_in = regs_out[2];
  assign instr_addr_mask_in = regs_out[3];
  assign data_addr_break_in = regs_out[4];
  assign data_addr_mask_in = regs_out[5];
  assign data_value_break_in = regs_out[6];
  assign data_value_mask_in = regs_out[7];
  sigr_pipe_model u_model (.seed_in(seed_in), .regs_out(regs_out),
    .exc_pc_out(exception_return_pc_in), .err_pc_out(error_return_pc_in));
  sigr_unit u_dut (.*);
  always #2 ref_clk_in = ~ref_clk_in;
  function automatic logic [63:0] sx(logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction : sx
  task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Issues one op with status {permit, exception, error, mode}.
  task automatic op(logic [2:0] k, logic [4:0] st, logic [31:0] w);
    @(negedge ref_clk_in);
    {irq_mask_all_op_in, irq_unmask_op_in, exception_return_op_in} = k;
    {user_irq_gate_permit_in, exception_level_in, error_level_in} = st[4:2];
    privilege_mode_field_in = st[1:0];
    coproc_usable_in = ~st[0];
    instr_word_in = w;
    issue_valid_in = 1'b1;
    @(negedge ref_clk_in);
    issue_valid_in = 1'b0;
  endtask : op
  task automatic t_gate;
    logic p;
    for (int i = 0; i < 32; i++) begin
      p = i[4] | i[3] | i[2] | (i[1:0] == 2'h0);
      op(3'h2, 5'h00, 32'h0);
      op(3'h4, 5'(i), 32'h0);
      chk("mask enable", !p, extra_interrupt_enable_out);
      op(3'h4, 5'h00, 32'h0);
      op(3'h2, 5'(i), 32'h0);
      chk("unmask enable", p, extra_interrupt_enable_out);
    end
    op(3'h6, 5'h00, 32'h0);
    chk("mask priority", 1'b0, extra_interrupt_enable_out);
    $display("gate test done");
  endtask : t_gate
  task automatic t_irq;
    logic e;
    for (int i = 0; i < 128; i++) begin
      op(i[6] ? 3'h2 : 3'h4, 5'h00, 32'h0);
      {global_interrupt_enable_in, exception_level_in, error_level_in,
        maskable_irq_in, serial_port_interrupt_in,
        nonmaskable_irq_in} = i[5:0];
      e = i[0] | i[1] | (i[2] & i[5] & i[6] & !i[4] & !i[3]);
      @(negedge ref_clk_in);
      chk("irq take", e, irq_take_out);
    end
    $display("irq test done");
  endtask : t_irq
  task automatic t_ret;
    @(negedge ref_clk_in);
    {irq_mask_all_op_in, irq_unmask_op_in, exception_return_op_in} = 3'h1;
    {issue_valid_in, error_level_in, seed_in} = {2'h3, 8'h9e};
    @(negedge ref_clk_in);
    chk("error clear", 1'b1, clear_error_level_out);
    chk("error keep", 1'b0, clear_exception_level_out);
    chk("error pc", error_return_pc_in, fetch_pc_out);
    chk("redirect", 1'b1, fetch_redirect_out);
    chk("flush", 1'b1, pipe_flush_out);
    chk("spare", 1'b1, spare_long_ops_out);
    {error_level_in, exception_level_in, seed_in} = {2'h1, 8'h21};
    @(negedge ref_clk_in);
    chk("exc clear", 1'b1, clear_exception_level_out);
    chk("exc keep", 1'b0, clear_error_level_out);
    chk("exc pc", exception_return_pc_in, fetch_pc_out);
    issue_valid_in = 1'b0;
    @(negedge ref_clk_in);
    chk("redirect end", 1'b0, fetch_redirect_out);
    chk("flush end", 1'b0, pipe_flush_out);
    chk("clear end", 1'b0, clear_exception_level_out);
    $display("return test done");
  endtask : t_ret
  task automatic t_mf;
    for (int j = 0; j < 16; j++) begin
      seed_in = j[3] ? 8'ha5 : 8'h5a;
      op(3'h0, 5'h00, {11'h200, 5'(j), 5'h18, 8'h00, j[2:0]});
      chk("gpr write", j[2:0] != 3'h1, gpr_write_out);
      if (j[2:0] != 3'h1) begin
        chk("gpr data", sx(regs_out[j[2:0]]), gpr_data_out);
        chk("gpr target", 5'(j), target_gpr_field_out);
      end
    end
    op(3'h0, 5'h00, {11'h200, 5'h1f, 5'h09, 11'h000});
    chk("plain read", sx(regs_out[1]), gpr_data_out);
    op(3'h0, 5'h00, {11'h200, 5'h1f, 5'h18, 8'h01, 3'h0});
    chk("pad refused", 1'b0, gpr_write_out);
    $display("move-from test done");
  endtask : t_mf
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    chk("reset enable", 1'b1, extra_interrupt_enable_out);
    t_gate();
    t_irq();
    t_ret();
    t_mf();
    end_sim();
  end
endmodule : sigr_unit_tb_top
`default_nettype wire
